// ==== hdl/gfm_pin_mux.v ====
// general purpose pin function selector with otp load and ahb-lite registers
//
// What this block does
// - load pin codes from otp after reset
// - eight-bit code per pin picks its role
// - code 0x00 leaves pin plain input
// - code 0x10 pin is ref0 external loss
// - code 0x14 pin is ref1 external loss
// - code 0x20 pin ored into time-error clear
// - codes 0x44/0x45 or into divider c stop
// - codes 0x46/0x47 or into divider d stop
// - code 0x60 pin ored into diff_out0 enable
// - codes 0x62/0x64/0x66 enable diff_out1..3
// - code 0x70 pin ored into cmos_out0 enable
// - code 0x72 pin ored into cmos_out1 enable
// - code 0x80 pin drives the interrupt
// - interrupt flags status changes for host read
// - code 0x88 drives ref0 no activity
// - code 0x89 drives ref0 single cycle failure
// - code 0x8a drives ref0 coarse frequency failure
// - ref0 failure is masked or of indicators
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`include "gfm_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module gfm_pin_mux
(
  // clock and reset
  input  wire                        sys_clk,
  input  wire                        resetn,
  // ahb-lite slave
  input  wire                        hsel,
  input  wire [7:0]                  haddr,
  input  wire [1:0]                  htrans,
  input  wire                        hwrite,
  input  wire [2:0]                  hsize,
  input  wire [31:0]                 hwdata,
  input  wire                        hready,
  output reg  [31:0]                 hrdata,
  output wire                        hreadyout,
  output wire                        hresp,
  // one-time-programmable store, one cycle read latency
  output wire [2:0]                  otp_addr,
  output wire                        otp_rd_en,
  input  wire [`GFM_CFG_W-1:0]       otp_data,
  // pins
  input  wire [`GFM_NPINS-1:0]       gpio_in,
  output reg  [`GFM_NPINS-1:0]       gpio_out,
  output reg  [`GFM_NPINS-1:0]       gpio_oe_n,
  // reference monitor indications
  input  wire                        ref0_no_activity,
  input  wire                        ref0_single_cycle_check,
  input  wire                        ref0_coarse_freq_check,
  input  wire                        ref0_guard_soak_flag,
  input  wire                        ref1_no_activity,
  input  wire                        ref1_single_cycle_check,
  input  wire                        ref1_coarse_freq_check,
  input  wire                        ref1_guard_soak_flag,
  // combined control to dpll, dividers and drivers
  output reg                         ref0_ext_los,
  output reg                         ref1_ext_los,
  output reg                         ref0_fail,
  output reg                         ref1_fail,
  output reg                         time_error_clear,
  output reg  [1:0]                  postdiv_c_stop,
  output reg  [1:0]                  postdiv_d_stop,
  output reg  [3:0]                  diff_out_en,
  output reg  [1:0]                  cmos_out_en,
  // interrupt
  output reg                         irq
);

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [1:0] ST_LOAD = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  // --------------------------------------------------------------------------
  // decode functions
  // --------------------------------------------------------------------------
  // one bit per control target; anything unlisted maps to nothing
  function [`GFM_NCTRL-1:0] gfm_ctrl_decode;
    input [`GFM_CFG_W-1:0] code;
    begin
      gfm_ctrl_decode = {`GFM_NCTRL{1'b0}};
      case (code)
        `GFM_C_REF0_LOS : gfm_ctrl_decode[0]  = 1'b1;
        `GFM_C_REF1_LOS : gfm_ctrl_decode[1]  = 1'b1;
        `GFM_C_TE_CLR   : gfm_ctrl_decode[2]  = 1'b1;
        `GFM_C_PDC_B1   : gfm_ctrl_decode[3]  = 1'b1;
        `GFM_C_PDC_B0   : gfm_ctrl_decode[4]  = 1'b1;
        `GFM_C_PDD_B1   : gfm_ctrl_decode[5]  = 1'b1;
        `GFM_C_PDD_B0   : gfm_ctrl_decode[6]  = 1'b1;
        `GFM_C_DIFF0    : gfm_ctrl_decode[7]  = 1'b1;
        `GFM_C_DIFF1    : gfm_ctrl_decode[8]  = 1'b1;
        `GFM_C_DIFF2    : gfm_ctrl_decode[9]  = 1'b1;
        `GFM_C_DIFF3    : gfm_ctrl_decode[10] = 1'b1;
        `GFM_C_CMOS0    : gfm_ctrl_decode[11] = 1'b1;
        `GFM_C_CMOS1    : gfm_ctrl_decode[12] = 1'b1;
        default         : gfm_ctrl_decode = {`GFM_NCTRL{1'b0}};
      endcase
    end
  endfunction

  // returns {drive, level}; drive low keeps the pin an input
  function [1:0] gfm_stat_decode;
    input [`GFM_CFG_W-1:0]  code;
    input [`GFM_NSTAT-1:0]  st;
    begin
      case (code)
        `GFM_S_IRQ_FULL : gfm_stat_decode = {1'b1, st[0]};
        `GFM_S_R0_NOACT : gfm_stat_decode = {1'b1, st[1]};
        `GFM_S_R0_SCC   : gfm_stat_decode = {1'b1, st[2]};
        `GFM_S_R0_CFC   : gfm_stat_decode = {1'b1, st[3]};
        `GFM_S_R0_GSF   : gfm_stat_decode = {1'b1, st[4]};
        `GFM_S_R0_FAIL  : gfm_stat_decode = {1'b1, st[5]};
        `GFM_S_R1_NOACT : gfm_stat_decode = {1'b1, st[6]};
        `GFM_S_R1_SCC   : gfm_stat_decode = {1'b1, st[7]};
        `GFM_S_R1_CFC   : gfm_stat_decode = {1'b1, st[8]};
        `GFM_S_R1_GSF   : gfm_stat_decode = {1'b1, st[9]};
        `GFM_S_R1_FAIL  : gfm_stat_decode = {1'b1, st[10]};
        default         : gfm_stat_decode = 2'b00;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  // config byte: status codes need bit 7 above the 6:0 code
  reg  [`GFM_CFG_W-1:0]    pin_cfg [0:`GFM_NPINS-1];
  reg  [1:0]               state;
  reg  [2:0]               ld_cnt;
  reg                      dpll_ctrl;
  reg  [3:0]               post_stop;
  reg  [3:0]               diff_en_reg;
  reg  [1:0]               cmos_en_reg;
  reg  [7:0]               fail_mask;
  reg  [`GFM_NEVT-1:0]     irq_status;
  reg  [`GFM_NEVT-1:0]     irq_en;
  reg  [`GFM_NEVT-1:0]     evt_prev;
  reg                      dp_act;
  reg                      dp_write;
  reg  [7:0]               dp_addr;
  reg  [31:0]              rd_mux;
  reg  [7:0]               rd_addr;
  reg  [`GFM_NEVT-1:0]     next_irq_status;

  wire                     run = state[1];
  wire                     addr_ok = hsel & htrans[1] & hready;
  wire                     wr_ok = dp_act & dp_write & run;
  wire [`GFM_NEVT-1:0]     evt_lvl;
  wire [`GFM_NEVT-1:0]     evt_rise;
  wire [`GFM_NSTAT-1:0]    stat_vec;
  wire [`GFM_NCTRL-1:0]    ctrl_acc [0:`GFM_NPINS];

  // --------------------------------------------------------------------------
  // otp load after reset
  // --------------------------------------------------------------------------
  // otp holds one code per pin; data for address k arrives one cycle later
  assign otp_addr  = ld_cnt;
  assign otp_rd_en = state[0] & (ld_cnt < `GFM_NPINS);

  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      state  <= ST_LOAD;
      ld_cnt <= 3'h0;
    end
    else
    begin
      case (state)
        ST_LOAD :
        begin
          ld_cnt <= ld_cnt + 3'h1;
          if (ld_cnt == `GFM_NPINS)
            state <= ST_RUN;
        end
        ST_RUN  : state <= ST_RUN;
        default : state <= ST_LOAD;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // ahb-lite slave
  // --------------------------------------------------------------------------
  // wait states until one edge after the otp load, so software never sees a
  // half-loaded code table, the last word included
  assign hreadyout = evt_prev[4] | ~dp_act;
  assign hresp     = 1'b0;

  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      dp_act   <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end
    else if (hreadyout)
    begin
      dp_act   <= addr_ok;
      dp_write <= hwrite;
      dp_addr  <= haddr;
    end
  end

  always @*
  begin
    rd_addr = addr_ok ? haddr : dp_addr;
    rd_mux  = 32'h0000_0000;
    if (rd_addr < `GFM_OFS_PIN_CFG0 + 4 * `GFM_NPINS && rd_addr[1:0] == 2'b00)
      rd_mux[7:0] = pin_cfg[rd_addr[4:2]];
    else
      case (rd_addr)
        `GFM_OFS_DPLL_CTRL : rd_mux[0]   = dpll_ctrl;
        `GFM_OFS_POST_STOP : rd_mux[3:0] = post_stop;
        `GFM_OFS_DIFF_EN   : rd_mux[3:0] = diff_en_reg;
        `GFM_OFS_CMOS_EN   : rd_mux[1:0] = cmos_en_reg;
        `GFM_OFS_FAIL_MASK : rd_mux[7:0] = fail_mask;
        `GFM_OFS_PIN_LVL   : rd_mux[5:0] = gpio_in;
        `GFM_OFS_IRQ_STAT  : rd_mux[4:0] = irq_status;
        `GFM_OFS_IRQ_EN    : rd_mux[4:0] = irq_en;
        default            : rd_mux = 32'h0000_0000;
      endcase
  end

  always @(posedge sys_clk)
  begin
    if (!resetn)
      hrdata <= 32'h0000_0000;
    else if ((addr_ok & hreadyout) | (dp_act & ~hreadyout))
      hrdata <= rd_mux;
  end

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  integer k;
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      for (k = 0; k < `GFM_NPINS; k = k + 1)
        pin_cfg[k] <= `GFM_RST_CODE;
      dpll_ctrl   <= 1'b0;
      post_stop   <= `GFM_RST_CTRL;
      diff_en_reg <= `GFM_RST_CTRL;
      cmos_en_reg <= 2'b00;
      fail_mask   <= `GFM_RST_MASK;
      irq_en      <= `GFM_RST_EVT;
    end
    else
    begin
      if (state[0] && ld_cnt != 3'h0)
        pin_cfg[ld_cnt - 3'h1] <= otp_data;
      if (wr_ok)
      begin
        if (dp_addr < `GFM_OFS_PIN_CFG0 + 4 * `GFM_NPINS && dp_addr[1:0] == 2'b00)
          pin_cfg[dp_addr[4:2]] <= hwdata[7:0];
        case (dp_addr)
          `GFM_OFS_DPLL_CTRL : dpll_ctrl   <= hwdata[0];
          `GFM_OFS_POST_STOP : post_stop   <= hwdata[3:0];
          `GFM_OFS_DIFF_EN   : diff_en_reg <= hwdata[3:0];
          `GFM_OFS_CMOS_EN   : cmos_en_reg <= hwdata[1:0];
          `GFM_OFS_FAIL_MASK : fail_mask   <= hwdata[7:0];
          `GFM_OFS_IRQ_EN    : irq_en      <= hwdata[4:0];
          default            : irq_en      <= irq_en;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // control inputs: per-pin decode, ored across pins
  // --------------------------------------------------------------------------
  assign ctrl_acc[0] = {`GFM_NCTRL{1'b0}};

  genvar g;
  generate
    for (g = 0; g < `GFM_NPINS; g = g + 1)
    begin : g_pin
      wire [1:0] drv = gfm_stat_decode(pin_cfg[g], stat_vec);
      // a status pin never feeds a control target
      assign ctrl_acc[g+1] = ctrl_acc[g] |
                             (gfm_ctrl_decode(pin_cfg[g]) & {`GFM_NCTRL{gpio_in[g]}});
      always @(posedge sys_clk)
      begin
        if (!resetn)
        begin
          gpio_out[g]  <= 1'b0;
          gpio_oe_n[g] <= 1'b1;
        end
        else
        begin
          gpio_out[g]  <= drv[0];
          gpio_oe_n[g] <= ~drv[1];
        end
      end
    end
  endgenerate

  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      ref0_ext_los     <= 1'b0;
      ref1_ext_los     <= 1'b0;
      time_error_clear <= 1'b0;
      postdiv_c_stop   <= 2'b00;
      postdiv_d_stop   <= 2'b00;
      diff_out_en      <= 4'h0;
      cmos_out_en      <= 2'b00;
      ref0_fail        <= 1'b0;
      ref1_fail        <= 1'b0;
    end
    else
    begin
      ref0_ext_los     <= ctrl_acc[`GFM_NPINS][0];
      ref1_ext_los     <= ctrl_acc[`GFM_NPINS][1];
      time_error_clear <= dpll_ctrl | ctrl_acc[`GFM_NPINS][2];
      postdiv_c_stop   <= post_stop[1:0] |
                          {ctrl_acc[`GFM_NPINS][3], ctrl_acc[`GFM_NPINS][4]};
      postdiv_d_stop   <= post_stop[3:2] |
                          {ctrl_acc[`GFM_NPINS][5], ctrl_acc[`GFM_NPINS][6]};
      diff_out_en      <= diff_en_reg | ctrl_acc[`GFM_NPINS][10:7];
      cmos_out_en      <= cmos_en_reg | ctrl_acc[`GFM_NPINS][12:11];
      ref0_fail <= (ctrl_acc[`GFM_NPINS][0] & fail_mask[0]) |
                   (ref0_single_cycle_check & fail_mask[1]) |
                   (ref0_coarse_freq_check  & fail_mask[2]) |
                   (ref0_guard_soak_flag    & fail_mask[3]);
      ref1_fail <= (ctrl_acc[`GFM_NPINS][1] & fail_mask[4]) |
                   (ref1_single_cycle_check & fail_mask[5]) |
                   (ref1_coarse_freq_check  & fail_mask[6]) |
                   (ref1_guard_soak_flag    & fail_mask[7]);
    end
  end

  // --------------------------------------------------------------------------
  // status vector for status pins
  // --------------------------------------------------------------------------
  assign stat_vec = {ref1_fail, ref1_guard_soak_flag, ref1_coarse_freq_check,
                     ref1_single_cycle_check, ref1_no_activity,
                     ref0_fail, ref0_guard_soak_flag, ref0_coarse_freq_check,
                     ref0_single_cycle_check, ref0_no_activity, irq};

  // --------------------------------------------------------------------------
  // interrupt: sticky status, write-one clear, enable
  // --------------------------------------------------------------------------
  // events are rising edges, so a steady failure raises one interrupt only
  assign evt_lvl  = {run, ref1_ext_los, ref0_ext_los, ref1_fail, ref0_fail};
  assign evt_rise = evt_lvl & ~evt_prev;

  always @*
  begin
    next_irq_status = irq_status;
    if (wr_ok && dp_addr == `GFM_OFS_IRQ_CLR)
      next_irq_status = next_irq_status & ~hwdata[4:0];
    next_irq_status = next_irq_status | evt_rise;
  end

  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      evt_prev   <= `GFM_RST_EVT;
      irq_status <= `GFM_RST_EVT;
      irq        <= 1'b0;
    end
    else
    begin
      evt_prev   <= evt_lvl;
      irq_status <= next_irq_status;
      irq        <= |(irq_status & irq_en);
    end
  end

endmodule // gfm_pin_mux

`default_nettype wire

// ==== hdl/gfm_defines.vh ====
// constants of the pin function selector: register offsets, codes, reset values
`ifndef GFM_DEFINES_VH
`define GFM_DEFINES_VH

// ----------------------------------------------------------------------------
// structure
// ----------------------------------------------------------------------------
`define GFM_NPINS         6
`define GFM_CODE_W        7
`define GFM_CFG_W         8
`define GFM_NCTRL         13
`define GFM_NSTAT         11
`define GFM_NEVT          5

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define GFM_OFS_PIN_CFG0  8'h00
`define GFM_OFS_DPLL_CTRL 8'h20
`define GFM_OFS_POST_STOP 8'h24
`define GFM_OFS_DIFF_EN   8'h28
`define GFM_OFS_CMOS_EN   8'h2c
`define GFM_OFS_FAIL_MASK 8'h30
`define GFM_OFS_PIN_LVL   8'h34
`define GFM_OFS_IRQ_STAT  8'h38
`define GFM_OFS_IRQ_CLR   8'h3c
`define GFM_OFS_IRQ_EN    8'h40

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define GFM_RST_CODE      8'h00
`define GFM_RST_CTRL      4'h0
`define GFM_RST_MASK      8'hff
`define GFM_RST_EVT       5'h00

// ----------------------------------------------------------------------------
// control codes
// ----------------------------------------------------------------------------
`define GFM_C_DEFAULT     8'h00
`define GFM_C_REF0_LOS    8'h10
`define GFM_C_REF1_LOS    8'h14
`define GFM_C_TE_CLR      8'h20
`define GFM_C_PDC_B1      8'h44
`define GFM_C_PDC_B0      8'h45
`define GFM_C_PDD_B1      8'h46
`define GFM_C_PDD_B0      8'h47
`define GFM_C_DIFF0       8'h60
`define GFM_C_DIFF1       8'h62
`define GFM_C_DIFF2       8'h64
`define GFM_C_DIFF3       8'h66
`define GFM_C_CMOS0       8'h70
`define GFM_C_CMOS1       8'h72

// ----------------------------------------------------------------------------
// status codes
// ----------------------------------------------------------------------------
`define GFM_S_IRQ_FULL    8'h80
`define GFM_S_R0_NOACT    8'h88
`define GFM_S_R0_SCC      8'h89
`define GFM_S_R0_CFC      8'h8a
`define GFM_S_R0_GSF      8'h8b
`define GFM_S_R0_FAIL     8'h8c
`define GFM_S_R1_NOACT    8'h90
`define GFM_S_R1_SCC      8'h91
`define GFM_S_R1_CFC      8'h92
`define GFM_S_R1_GSF      8'h93
`define GFM_S_R1_FAIL     8'h94

`endif

// ==== dv/gfm_pin_mux_sva.sv ====
// assertion checker for the pin function selector
`include "gfm_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module gfm_pin_mux_sva
(
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  // bus and otp
  input wire logic                  hresp,
  input wire logic                  hreadyout,
  input wire logic [2:0]            otp_addr,
  input wire logic                  otp_rd_en,
  // pins and outputs
  input wire logic [`GFM_NPINS-1:0] gpio_in,
  input wire logic [`GFM_NPINS-1:0] gpio_oe_n,
  input wire logic [3:0]            diff_out_en,
  input wire logic                  irq,
  input wire logic                  ref0_ext_los,
  input wire logic                  ref1_ext_los,
  input wire logic                  ref0_fail,
  input wire logic                  ref1_fail,
  // monitor indications
  input wire logic                  ref0_single_cycle_check,
  input wire logic                  ref0_coarse_freq_check,
  input wire logic                  ref0_guard_soak_flag,
  input wire logic                  ref1_single_cycle_check,
  input wire logic                  ref1_coarse_freq_check,
  input wire logic                  ref1_guard_soak_flag
);
  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // fail shares its edge with the registered loss; indicators are one edge back
  wire any_pin = |gpio_in;
  wire src0 = ref0_single_cycle_check | ref0_coarse_freq_check | ref0_guard_soak_flag;
  wire src1 = ref1_single_cycle_check | ref1_coarse_freq_check | ref1_guard_soak_flag;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // --------------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------------
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_reset_vals: assert property ($rose(resetn) |-> gpio_oe_n == {`GFM_NPINS{1'b1}}
    && diff_out_en == 4'h0 && !irq)
    else $error("outputs not at reset values");
  a_otp_start: assert property ($rose(resetn) |-> ##[0:2] (otp_rd_en && otp_addr == 3'd0))
    else $error("otp load did not start");
  a_otp_range: assert property (otp_rd_en |-> otp_addr <= 3'd5)
    else $error("otp read beyond last pin");
  a_otp_step: assert property (otp_rd_en && otp_addr < 3'd5 |=>
    otp_rd_en && otp_addr == $past(otp_addr) + 3'd1)
    else $error("otp address sequence broken");
  a_ready_run: assert property (!otp_rd_en [*4] |-> hreadyout)
    else $error("bus stalled after load");
  a_los0_pin: assert property (ref0_ext_los |-> $past(any_pin, 1) || $past(any_pin, 2))
    else $error("ref0 loss without pin");
  a_los1_pin: assert property (ref1_ext_los |-> $past(any_pin, 1) || $past(any_pin, 2))
    else $error("ref1 loss without pin");
  a_fail0_cause: assert property (ref0_fail |-> ref0_ext_los || $past(src0, 1))
    else $error("ref0 failure without cause");
  a_fail1_cause: assert property (ref1_fail |-> ref1_ext_los || $past(src1, 1))
    else $error("ref1 failure without cause");
endmodule // gfm_pin_mux_sva

bind gfm_pin_mux gfm_pin_mux_sva u_sva
(
  .sys_clk(sys_clk), .resetn(resetn), .hresp(hresp), .hreadyout(hreadyout),
  .otp_addr(otp_addr), .otp_rd_en(otp_rd_en), .gpio_in(gpio_in), .gpio_oe_n(gpio_oe_n),
  .diff_out_en(diff_out_en), .irq(irq), .ref0_ext_los(ref0_ext_los),
  .ref1_ext_los(ref1_ext_los), .ref0_fail(ref0_fail), .ref1_fail(ref1_fail),
  .ref0_single_cycle_check(ref0_single_cycle_check),
  .ref0_coarse_freq_check(ref0_coarse_freq_check),
  .ref0_guard_soak_flag(ref0_guard_soak_flag),
  .ref1_single_cycle_check(ref1_single_cycle_check),
  .ref1_coarse_freq_check(ref1_coarse_freq_check),
  .ref1_guard_soak_flag(ref1_guard_soak_flag)
);
`default_nettype wire

// ==== dv/gfm_board.sv ====
// board side: otp image store and pin levels
`timescale 1ns/10ps
`default_nettype none

module gfm_board
(
  // clock
  input  wire logic        sys_clk,
  // otp store
  input  wire logic [47:0] image,
  input  wire logic [2:0]  otp_addr,
  input  wire logic        otp_rd_en,
  output var  logic [7:0]  otp_data = 8'h2a,
  // pins
  input  wire logic [5:0]  lvl,
  input  wire logic [5:0]  gpio_out,
  input  wire logic [5:0]  gpio_oe_n,
  output wire logic [5:0]  gpio_in
);
  // one cycle latency; outside reads the word toggles so stale data is never seen
  always @(posedge sys_clk)
    otp_data <= otp_rd_en ? image[otp_addr * 8 +: 8] : ~otp_data;
  // a pin the block drives shows its level, else the board's level
  assign gpio_in = (gpio_out & ~gpio_oe_n) | (lvl & gpio_oe_n);
endmodule // gfm_board
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench of the pin function selector
`include "gfm_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic        sys_clk, resetn, hsel, hwrite, hreadyout, hresp, irq, otp_rd_en;
  logic [7:0]  haddr, mon, mask;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic [2:0]  otp_addr;
  logic [7:0]  otp_data;
  logic [5:0]  gpio_in, gpio_out, gpio_oe_n, lvl;
  logic [47:0] image;
  logic [10:0] mdl;
  logic [12:0] e;
  wire  [12:0] ctl;
  wire  [1:0]  fail;
  int          bad_count, check_count, codes[6], p, i, k;
  logic [7:0]  ctab[15] = '{`GFM_C_REF0_LOS, `GFM_C_REF1_LOS, `GFM_C_TE_CLR, `GFM_C_PDC_B1,
    `GFM_C_PDC_B0, `GFM_C_PDD_B1, `GFM_C_PDD_B0, `GFM_C_DIFF0, `GFM_C_DIFF1, `GFM_C_DIFF2,
    `GFM_C_DIFF3, `GFM_C_CMOS0, `GFM_C_CMOS1, `GFM_C_DEFAULT, 8'h33};
  int          btab[13] = '{12, 11, 10, 9, 8, 7, 6, 2, 3, 4, 5, 0, 1};
  logic [7:0]  stab[8] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h90, 8'h91, 8'h92, 8'h93};
  int          sbit[8] = '{6, 0, 1, 2, 7, 3, 4, 5};

  gfm_pin_mux dut
  (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .otp_addr(otp_addr), .otp_rd_en(otp_rd_en),
    .otp_data(otp_data), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .ref0_no_activity(mon[6]), .ref0_single_cycle_check(mon[0]),
    .ref0_coarse_freq_check(mon[1]), .ref0_guard_soak_flag(mon[2]),
    .ref1_no_activity(mon[7]), .ref1_single_cycle_check(mon[3]),
    .ref1_coarse_freq_check(mon[4]), .ref1_guard_soak_flag(mon[5]),
    .ref0_ext_los(ctl[12]), .ref1_ext_los(ctl[11]), .ref0_fail(fail[0]), .ref1_fail(fail[1]),
    .time_error_clear(ctl[10]), .postdiv_c_stop(ctl[9:8]), .postdiv_d_stop(ctl[7:6]),
    .diff_out_en(ctl[5:2]), .cmos_out_en(ctl[1:0]), .irq(irq)
  );

  gfm_board board
  (
    .sys_clk(sys_clk), .image(image), .otp_addr(otp_addr), .otp_rd_en(otp_rd_en),
    .otp_data(otp_data), .lvl(lvl), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .gpio_in(gpio_in)
  );

  // --------------------------------------------------------------------------
  // model and tasks
  // --------------------------------------------------------------------------
  // register bits first, then every high pin ors in the bit its code selects
  function automatic logic [12:0] exp_ctl(input logic [5:0] l);
    logic [12:0] r;
    r = {2'b00, mdl};
    for (int n = 0; n < 6; n++)
      for (int j = 0; j < 13; j++)
        if (l[n] && codes[n] == ctab[j])
          r[btab[j]] = 1'b1;
    return r;
  endfunction

  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // the wait bound covers the otp load stall as well
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1 && ++n < 100);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1 && ++n < 200);
    rd = hrdata;
    if (n >= 200)
    begin
      bad_count++;
      wrap_up();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(rd, x);
  endtask

  // --------------------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial
  begin
    {resetn, hsel, hwrite, haddr, htrans, hwdata, mon, lvl, mdl} = '0;
    bad_count = 0;
    check_count = 0;
    void'($urandom(32'h54d2));
    for (i = 0; i < 6; i++)
    begin
      image[i * 8 +: 8] = ctab[$urandom % 15];
      codes[i] = image[i * 8 +: 8];
    end
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    for (i = 0; i < 6; i++) rchk(8'(4 * i), codes[i]);
    for (i = 0; i < 6; i++) rchk(8'h20 + 8'(4 * i), (i == 4) ? 32'hff : 32'h0);
    bus(1'b1, `GFM_OFS_IRQ_STAT, 32'h0);
    rchk(`GFM_OFS_IRQ_STAT, 32'h10);
    bus(1'b1, `GFM_OFS_IRQ_EN, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b1);
    bus(1'b1, `GFM_OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    bus(1'b1, `GFM_OFS_IRQ_EN, 32'h1f);
    bus(1'b1, `GFM_OFS_IRQ_CLR, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
    rchk(`GFM_OFS_IRQ_CLR, 32'h0);
    bus(1'b1, 8'h80, 32'hffff_ffff);
    rchk(8'h80, 32'h0);
    mon <= 8'h01;
    repeat (4) @(posedge sys_clk);
    rchk(`GFM_OFS_IRQ_STAT, 32'h01);
    chk(irq, 1'b1);
    bus(1'b1, `GFM_OFS_IRQ_CLR, 32'h1f);
    rchk(`GFM_OFS_IRQ_STAT, 32'h0);
    // every control code twice, on random pins, over random register bits
    for (k = 0; k < 30; k++)
    begin
      p = $urandom % 6;
      codes[p] = ctab[k % 15];
      mdl = 11'($urandom & $urandom);
      mask = 8'($urandom);
      bus(1'b1, 8'(4 * p), codes[p]);
      bus(1'b1, `GFM_OFS_DPLL_CTRL, 32'(mdl[10]));
      bus(1'b1, `GFM_OFS_POST_STOP, {28'h0, mdl[7:6], mdl[9:8]});
      bus(1'b1, `GFM_OFS_DIFF_EN, 32'(mdl[5:2]));
      bus(1'b1, `GFM_OFS_CMOS_EN, 32'(mdl[1:0]));
      bus(1'b1, `GFM_OFS_FAIL_MASK, 32'(mask));
      lvl <= (k % 3 == 0) ? 6'h3f : 6'($urandom);
      mon <= 8'($urandom);
      repeat (4) @(posedge sys_clk);
      e = exp_ctl(lvl);
      chk(ctl, e);
      chk(gpio_oe_n, 6'h3f);
      chk(fail, {|({mon[5:3], e[11]} & mask[7:4]), |({mon[2:0], e[12]} & mask[3:0])});
      rchk(`GFM_OFS_PIN_LVL, 32'(lvl));
      rchk(8'(4 * p), codes[p]);
    end
    // status codes on pin 0: driven, at the level of the selected source
    for (k = 0; k < 8; k++)
    begin
      mon <= 8'($urandom);
      bus(1'b1, 8'h00, 32'(stab[k]));
      repeat (3) @(posedge sys_clk);
      chk({gpio_oe_n[0], gpio_out[0]}, {1'b0, mon[sbit[k]]});
    end
    // interrupt on pin 0: quiet first, then a failure rise meeting a clear
    bus(1'b1, 8'h00, 32'h80);
    bus(1'b1, `GFM_OFS_FAIL_MASK, 32'hff);
    bus(1'b1, `GFM_OFS_IRQ_EN, 32'h01);
    lvl <= 6'h00;
    for (k = 0; k < 2; k++)
    begin
      mon <= 8'(k);
      bus(1'b1, `GFM_OFS_IRQ_CLR, 32'h1f);
      repeat (4) @(posedge sys_clk);
      chk({gpio_oe_n[0], gpio_out[0]}, {1'b0, 1'(k)});
    end
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
